// [nqab_pkg.sv]
// shared constants for the queue abort / deadline subcommand ends
package nqab_pkg;
    // command and device/head pattern
    localparam logic [7:0] NQAB_OPCODE          = 8'h63;
    localparam int         NQAB_DEVHEAD_ONE_BIT = 6;
    localparam int         NQAB_DEVHEAD_ZERO_BIT = 4;
    localparam logic [7:0] NQAB_DEVHEAD_VALUE   = 8'h40;
    // feature field layout, and tag position in count/sector fields
    localparam int         NQAB_SUBCMD_LSB = 0;
    localparam int         NQAB_TYPE_LSB   = 4;
    localparam int         NQAB_WSTRICT_BIT = 4;
    localparam int         NQAB_RSTRICT_BIT = 5;
    localparam int         NQAB_TAG_LSB    = 3;
    // subcommand codes
    localparam logic [3:0] NQAB_SUB_ABORT    = 4'h0;
    localparam logic [3:0] NQAB_SUB_DEADLINE = 4'h1;
    // abort types
    localparam logic [3:0] NQAB_ABORT_ALL       = 4'h0;
    localparam logic [3:0] NQAB_ABORT_STREAM    = 4'h1;
    localparam logic [3:0] NQAB_ABORT_NONSTREAM = 4'h2;
    localparam logic [3:0] NQAB_ABORT_SELECTED  = 4'h3;
    localparam logic [15:0] NQAB_TYPES_DEFAULT  = 16'h000f;
    // error and status byte bits
    localparam int         NQAB_ERR_ABORT_BIT = 2;
    localparam int         NQAB_ST_BUSY_BIT   = 7;
    localparam int         NQAB_ST_READY_BIT  = 6;
    localparam int         NQAB_ST_FAULT_BIT  = 5;
    localparam int         NQAB_ST_SEEK_BIT   = 4;
    localparam int         NQAB_ST_ERR_BIT    = 0;
    localparam logic [7:0] NQAB_STATUS_RESET  = 8'h50;
    // controller register offsets
    localparam logic [3:0] NQAB_REG_CMD    = 4'h0;
    localparam logic [3:0] NQAB_REG_EVENTS = 4'h4;
    localparam logic [3:0] NQAB_REG_MASK   = 4'h8;
    localparam logic [3:0] NQAB_REG_RESULT = 4'hc;
    // controller command word layout
    localparam int         NQAB_CW_FEAT_LSB = 0;
    localparam int         NQAB_CW_TAG_LSB  = 8;
    localparam int         NQAB_CW_TARGET_QUEUE_TAG_LSB = 16;
    // controller event bits
    localparam int         NQAB_EV_OK_BIT    = 0;
    localparam int         NQAB_EV_ABORT_BIT = 1;
    localparam logic [1:0] NQAB_MASK_RESET   = 2'h0;
endpackage : nqab_pkg

// [nqab_link_if.sv]
// command/completion link joining controller and drive ends
interface nqab_link_if;
    // command block from controller
    logic        cmd_valid;       // one-cycle issue strobe
    logic [7:0]  cmd_code;        // command opcode
    logic [7:0]  cmd_feature;     // current feature field
    logic [7:0]  cmd_count;       // current sector count field
    logic [7:0]  cmd_sector;      // current sector number field
    logic [7:0]  cmd_devhead;     // device/head field
    // answer from drive
    logic        dev_ready;       // drive can take a command
    logic        done_valid;      // one-cycle completion strobe
    logic        done_sdb;        // completion is a set device bits frame
    logic [31:0] queue_active_bits; // tags reported complete
    logic [7:0]  done_status;     // status byte
    logic [7:0]  done_error;      // error byte
    modport dev (input cmd_valid, cmd_code, cmd_feature, cmd_count, cmd_sector, cmd_devhead,
                 output dev_ready, done_valid, done_sdb, queue_active_bits, done_status, done_error);
    modport host (output cmd_valid, cmd_code, cmd_feature, cmd_count, cmd_sector, cmd_devhead,
                  input dev_ready, done_valid, done_sdb, queue_active_bits, done_status, done_error);
endinterface : nqab_link_if

// [nqab_tag_select.sv]
// picks which outstanding tags an abort type cancels
module nqab_tag_select
    import nqab_pkg::*;
(
    // request
    input  wire logic [3:0]  abort_type,
    input  wire logic [4:0]  target_queue_tag,
    // queue view
    input  wire logic [31:0] outstanding,
    input  wire logic [31:0] streaming,
    // result
    output logic      [31:0] cancel_mask
);
    // one selector per tag; unknown types cancel nothing
    for (genvar t = 0; t < 32; t++) begin : g_tag
        always_comb begin
            unique case (abort_type)
                NQAB_ABORT_ALL:       cancel_mask[t] = outstanding[t];
                NQAB_ABORT_STREAM:    cancel_mask[t] = outstanding[t] & streaming[t];
                NQAB_ABORT_NONSTREAM: cancel_mask[t] = outstanding[t] & ~streaming[t];
                NQAB_ABORT_SELECTED:  cancel_mask[t] = outstanding[t] &
                                                       (target_queue_tag == 5'(t));
                default:              cancel_mask[t] = 1'b0;
            endcase
        end
    end
endmodule // nqab_tag_select

// [nqab_device.sv]
// drive end: decodes and runs the queue abort and deadline subcommands
// Notes on behaviour
// - feature low nibble zero means abort
// - feature high nibble selects abort type
// - type zero cancels every outstanding command
// - type one cancels streaming commands only
// - type two cancels non-streaming commands only
// - type three cancels the target tag
// - target tag in sector number bits 7-3
// - own tag in count bits 7-3, unique
// - supported type completes successfully unless an abort rule below applies
// - success frame sets own and cancelled bits
// - abort if queuing disabled or type unsupported
// - abort if target equals own or invalid
// - subcommand one selects deadline handling
// - recognise opcode 63h, dev/head pattern
// - deadline bits make isochronous transfers strict
module nqab_device
    import nqab_pkg::*;
#(
    parameter logic [15:0] SUPPORTED_TYPES = NQAB_TYPES_DEFAULT  // abort types the queue log lists
)(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // link to controller
    nqab_link_if.dev         link,
    // view of the drive's command queue
    input  wire logic        ncq_enabled,
    input  wire logic [4:0]  max_queue_tag,
    input  wire logic [31:0] outstanding_tags,
    input  wire logic [31:0] streaming_tags,
    // actions towards the drive's queue
    output logic             cancel_strobe_q,
    output logic      [31:0] cancel_tags_q,
    output logic             write_deadline_strict_q,
    output logic             read_deadline_strict_q,
    // last result bytes
    output logic      [7:0]  command_error_bits_q,
    output logic      [7:0]  device_condition_bits_q
);
    typedef enum logic [0:0] {
        NQAB_IDLE = 1'b0,   // waiting for a command
        NQAB_EXEC = 1'b1    // command latched, outcome computed here
    } nqab_dev_state_type;

    nqab_dev_state_type state_q, state_d;   // sequencer state
    logic [7:0]  feature_q, feature_d;      // latched feature field
    logic [4:0]  own_tag_q, own_tag_d;      // this command's tag
    logic [4:0]  target_queue_tag_q, target_queue_tag_d;            // latched target tag
    logic        ready_q, ready_d;          // drives link ready
    logic        done_q, done_d;            // completion strobe
    logic        sdb_q, sdb_d;              // success frame flag
    logic [31:0] active_q, active_d;        // reported active bits
    logic        cancel_d;                  // next cancel strobe
    logic [31:0] cancel_tags_d;             // next cancel set
    logic        wstrict_d, rstrict_d;      // next deadline modes
    logic [7:0]  err_d, stat_d;             // next result bytes
    logic [31:0] sel_mask;                  // tags chosen by type
    logic        take;                      // command accepted now
    logic [3:0]  subcmd, abort_type;        // feature split
    logic        bad;                       // command fails

    // subcommand and abort type taken from the latched feature byte
    assign subcmd     = feature_q[NQAB_SUBCMD_LSB +: 4];
    assign abort_type = feature_q[NQAB_TYPE_LSB +: 4];

    // only the queue management opcode with the right device/head pattern
    assign take = (state_q == NQAB_IDLE) && link.cmd_valid && (link.cmd_code == NQAB_OPCODE)
                  && link.cmd_devhead[NQAB_DEVHEAD_ONE_BIT]
                  && !link.cmd_devhead[NQAB_DEVHEAD_ZERO_BIT];

    // tag selection per abort type
    nqab_tag_select u_select (
        .abort_type       (abort_type),
        .target_queue_tag (target_queue_tag_q),
        .outstanding      (outstanding_tags),
        .streaming        (streaming_tags),
        .cancel_mask      (sel_mask)
    );

    // failure decision; queue enable sampled at execution, one cycle after issue
    always_comb begin
        bad = !ncq_enabled;
        unique case (subcmd)
            NQAB_SUB_ABORT: begin
                if (!SUPPORTED_TYPES[abort_type]) begin
                    bad = 1'b1;
                end
                if (abort_type == NQAB_ABORT_SELECTED) begin
                    // target checked only for a selected abort
                    if (target_queue_tag_q == own_tag_q || target_queue_tag_q > max_queue_tag) begin
                        bad = 1'b1;
                    end
                end
            end
            NQAB_SUB_DEADLINE: begin
                bad = !ncq_enabled;
            end
            default: begin
                bad = 1'b1;   // no other subcommand exists here
            end
        endcase
    end

    // next values of the sequencer and its outputs
    always_comb begin
        state_d       = state_q;
        feature_d     = feature_q;
        own_tag_d     = own_tag_q;
        target_queue_tag_d        = target_queue_tag_q;
        ready_d       = ready_q;
        done_d        = 1'b0;
        sdb_d         = sdb_q;
        active_d      = active_q;
        cancel_d      = 1'b0;
        cancel_tags_d = cancel_tags_q;
        wstrict_d     = write_deadline_strict_q;
        rstrict_d     = read_deadline_strict_q;
        err_d         = command_error_bits_q;
        stat_d        = device_condition_bits_q;
        unique case (state_q)
            NQAB_IDLE: begin
                ready_d = 1'b1;   // idle drive takes commands
                if (take) begin
                    // latch the command block, go busy for one cycle
                    feature_d = link.cmd_feature;
                    own_tag_d = link.cmd_count[NQAB_TAG_LSB +: 5];
                    target_queue_tag_d    = link.cmd_sector[NQAB_TAG_LSB +: 5];
                    ready_d   = 1'b0;
                    state_d   = NQAB_EXEC;
                end
            end
            NQAB_EXEC: begin
                done_d  = 1'b1;
                ready_d = 1'b1;
                state_d = NQAB_IDLE;
                stat_d  = NQAB_STATUS_RESET;   // ready and seek set, busy/fault clear
                if (bad) begin
                    // failure: error register abort bit, status error bit
                    sdb_d    = 1'b0;
                    active_d = '0;
                    err_d    = 8'h00;
                    err_d[NQAB_ERR_ABORT_BIT] = 1'b1;
                    stat_d[NQAB_ST_ERR_BIT]   = 1'b1;
                end else begin
                    // success even when nothing matched
                    sdb_d    = 1'b1;
                    err_d    = 8'h00;
                    active_d = 32'h0000_0001 << own_tag_q;
                    if (subcmd == NQAB_SUB_ABORT) begin
                        active_d      = active_d | sel_mask;
                        cancel_d      = |sel_mask;
                        cancel_tags_d = sel_mask;
                    end else begin
                        // strict deadline modes for isochronous writes/reads
                        wstrict_d = feature_q[NQAB_WSTRICT_BIT];
                        rstrict_d = feature_q[NQAB_RSTRICT_BIT];
                    end
                end
            end
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q                 <= NQAB_IDLE;
            feature_q               <= 8'h00;
            own_tag_q               <= 5'h00;
            target_queue_tag_q                  <= 5'h00;
            ready_q                 <= 1'b0;
            done_q                  <= 1'b0;
            sdb_q                   <= 1'b0;
            active_q                <= 32'h0000_0000;
            cancel_strobe_q         <= 1'b0;
            cancel_tags_q           <= 32'h0000_0000;
            write_deadline_strict_q <= 1'b0;
            read_deadline_strict_q  <= 1'b0;
            command_error_bits_q    <= 8'h00;
            device_condition_bits_q <= NQAB_STATUS_RESET;
        end else begin
            state_q                 <= state_d;
            feature_q               <= feature_d;
            own_tag_q               <= own_tag_d;
            target_queue_tag_q                  <= target_queue_tag_d;
            ready_q                 <= ready_d;
            done_q                  <= done_d;
            sdb_q                   <= sdb_d;
            active_q                <= active_d;
            cancel_strobe_q         <= cancel_d;
            cancel_tags_q           <= cancel_tags_d;
            write_deadline_strict_q <= wstrict_d;
            read_deadline_strict_q  <= rstrict_d;
            command_error_bits_q    <= err_d;
            device_condition_bits_q <= stat_d;
        end
    end

    // link outputs straight from flops
    assign link.dev_ready         = ready_q;
    assign link.done_valid        = done_q;
    assign link.done_sdb          = sdb_q;
    assign link.queue_active_bits = active_q;
    assign link.done_status       = device_condition_bits_q;
    assign link.done_error        = command_error_bits_q;
endmodule // nqab_device

// [nqab_host.sv]
// controller end: software register port that issues one subcommand at a time
module nqab_host
    import nqab_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // link to drive
    nqab_link_if.host        link,
    // software register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata_q,
    // interrupt
    output logic             irq_q
);
    typedef enum logic [1:0] {
        NQAB_H_IDLE = 2'b00,   // no command in flight
        NQAB_H_SEND = 2'b01,   // waiting for drive ready
        NQAB_H_WAIT = 2'b10    // waiting for completion
    } nqab_host_state_type;

    nqab_host_state_type state_q, state_d;  // issue sequencer
    logic [7:0]  feat_q, feat_d;            // feature to send
    logic [7:0]  cnt_q, cnt_d;              // sector count to send
    logic [7:0]  sec_q, sec_d;              // sector number to send
    logic        valid_q, valid_d;          // issue strobe
    logic [1:0]  ev_q, ev_d;                // sticky events
    logic [1:0]  mask_q, mask_d;            // event mask
    logic [7:0]  rstat_q, rstat_d;          // captured status byte
    logic [7:0]  rerr_q, rerr_d;            // captured error byte
    logic [31:0] rdata_d;                   // next read data
    logic        wr_cmd;                    // command word written

    assign wr_cmd = reg_write && (reg_addr == NQAB_REG_CMD);

    // issue sequencer; a command written while busy is dropped
    always_comb begin
        state_d = state_q;
        feat_d  = feat_q;
        cnt_d   = cnt_q;
        sec_d   = sec_q;
        valid_d = 1'b0;
        unique case (state_q)
            NQAB_H_IDLE: begin
                if (wr_cmd) begin
                    feat_d  = reg_wdata[NQAB_CW_FEAT_LSB +: 8];
                    cnt_d   = {reg_wdata[NQAB_CW_TAG_LSB +: 5], 3'h0};
                    sec_d   = {reg_wdata[NQAB_CW_TARGET_QUEUE_TAG_LSB +: 5], 3'h0};
                    state_d = NQAB_H_SEND;
                end
            end
            NQAB_H_SEND: begin
                if (link.dev_ready) begin
                    valid_d = 1'b1;
                    state_d = NQAB_H_WAIT;
                end
            end
            NQAB_H_WAIT: begin
                if (link.done_valid) begin
                    state_d = NQAB_H_IDLE;
                end
            end
            default: begin
                state_d = NQAB_H_IDLE;   // code 2'b11 is illegal
            end
        endcase
    end

    // result capture, sticky events (set beats clear), mask and read mux
    always_comb begin
        ev_d    = ev_q;
        mask_d  = mask_q;
        rstat_d = rstat_q;
        rerr_d  = rerr_q;
        if (reg_write && reg_addr == NQAB_REG_EVENTS) begin
            ev_d = ev_q & ~reg_wdata[1:0];
        end
        if (reg_write && reg_addr == NQAB_REG_MASK) begin
            mask_d = reg_wdata[1:0];
        end
        if (link.done_valid) begin
            rstat_d = link.done_status;
            rerr_d  = link.done_error;
            if (link.done_sdb) begin
                ev_d[NQAB_EV_OK_BIT] = 1'b1;
            end else begin
                ev_d[NQAB_EV_ABORT_BIT] = 1'b1;
            end
        end
        rdata_d = 32'h0000_0000;   // unmapped offsets read zero
        if (reg_read) begin
            unique case (reg_addr)
                NQAB_REG_CMD:    rdata_d = {8'h00, sec_q, cnt_q, feat_q};
                NQAB_REG_EVENTS: rdata_d = {30'h0, ev_q};
                NQAB_REG_MASK:   rdata_d = {30'h0, mask_q};
                NQAB_REG_RESULT: rdata_d = {15'h0, (state_q != NQAB_H_IDLE), rerr_q, rstat_q};
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // registers of the controller
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q     <= NQAB_H_IDLE;
            feat_q      <= 8'h00;
            cnt_q       <= 8'h00;
            sec_q       <= 8'h00;
            valid_q     <= 1'b0;
            ev_q        <= 2'h0;
            mask_q      <= NQAB_MASK_RESET;
            rstat_q     <= 8'h00;
            rerr_q      <= 8'h00;
            reg_rdata_q <= 32'h0000_0000;
            irq_q       <= 1'b0;
        end else begin
            state_q     <= state_d;
            feat_q      <= feat_d;
            cnt_q       <= cnt_d;
            sec_q       <= sec_d;
            valid_q     <= valid_d;
            ev_q        <= ev_d;
            mask_q      <= mask_d;
            rstat_q     <= rstat_d;
            rerr_q      <= rerr_d;
            reg_rdata_q <= rdata_d;
            irq_q       <= |(ev_d & mask_d);
        end
    end

    // fixed opcode and device/head pattern
    assign link.cmd_valid   = valid_q;
    assign link.cmd_code    = NQAB_OPCODE;
    assign link.cmd_devhead = NQAB_DEVHEAD_VALUE;
    assign link.cmd_feature = feat_q;
    assign link.cmd_count   = cnt_q;
    assign link.cmd_sector  = sec_q;
endmodule // nqab_host

// [nqab_link_monitor.sv]
// concurrent checks on the link joining controller and drive ends
module nqab_link_monitor
    import nqab_pkg::*;
#(
    parameter logic [15:0] SUPPORTED_TYPES = NQAB_TYPES_DEFAULT  // abort types the drive lists
)(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // command side
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [7:0]  cmd_feature,
    input wire logic [7:0]  cmd_count,
    input wire logic [7:0]  cmd_sector,
    input wire logic [7:0]  cmd_devhead,
    // answer side
    input wire logic        dev_ready,
    input wire logic        done_valid,
    input wire logic        done_sdb,
    input wire logic [31:0] queue_active_bits,
    input wire logic [7:0]  done_status,
    input wire logic [7:0]  done_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic       take;     // command the drive must accept
    logic [4:0] own_tag;  // tag of the command itself
    assign take    = cmd_valid && dev_ready && cmd_code == 8'h63 && cmd_devhead[6] && !cmd_devhead[4];
    assign own_tag = cmd_count[7:3];
    // accepted command, then its completion two edges on
    sequence s_taken;
        take;
    endsequence
    sequence s_answer;
        ##1 !done_valid ##1 done_valid;
    endsequence
    answer_timing_a: assert property (s_taken |-> s_answer)
        else $error("completion missing two cycles after command");
    no_stray_a: assert property (done_valid |-> $past(take, 2))
        else $error("completion without command");
    busy_window_a: assert property (s_taken |=> !dev_ready ##1 dev_ready)
        else $error("ready window wrong");
    fail_bytes_a: assert property (done_valid && !done_sdb |->
        done_error == 8'h04 && done_status == 8'h51 && queue_active_bits == 32'h0)
        else $error("aborted bytes wrong");
    ok_bytes_a: assert property (done_valid && done_sdb |-> done_error == 8'h00 && done_status == 8'h50)
        else $error("success bytes wrong");
    own_bit_a: assert property (s_taken ##2 done_sdb |-> queue_active_bits[$past(own_tag, 2)])
        else $error("own tag bit missing");
    bad_sub_a: assert property (take && cmd_feature[3:0] > 4'h1 |-> ##2 !done_sdb)
        else $error("unknown subcommand not aborted");
    same_tag_a: assert property (take && cmd_feature == 8'h30 &&
        cmd_sector[7:3] == own_tag |-> ##2 !done_sdb)
        else $error("target equal to own tag not aborted");
    type_list_a: assert property (take && cmd_feature[3:0] == 4'h0 &&
        !SUPPORTED_TYPES[cmd_feature[7:4]] |-> ##2 !done_sdb)
        else $error("unlisted abort type not aborted");
    hold_result_a: assert property (!done_valid |->
        $stable({done_status, done_error, queue_active_bits}))
        else $error("result changed between completions");
    host_form_a: assert property (cmd_valid |-> dev_ready &&
        cmd_code == NQAB_OPCODE && cmd_devhead == NQAB_DEVHEAD_VALUE)
        else $error("controller issued malformed command");
endmodule // nqab_link_monitor

// [ncq_queue_abort_subcommand_test.sv]
// self-checking bench: controller and drive ends joined over the link
module ncq_queue_abort_subcommand_test import nqab_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;  // 125 MHz
    logic        sys_rst = 1'b1;   // held 12 cycles
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata_q, cancel_tags_q;
    logic        irq_q, cancel_strobe_q, write_deadline_strict_q, read_deadline_strict_q;
    logic [7:0]  command_error_bits_q, device_condition_bits_q;
    logic        ncq_enabled = 1'b1;
    logic [4:0]  max_queue_tag = 5'h0f;
    logic [31:0] outstanding_tags = 32'h0;
    logic [31:0] streaming_tags = 32'h0;
    logic [31:0] seed = 32'hc241;  // fixed start keeps runs repeatable
    int          err_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // hand-picked feature values run first
    logic [7:0]  corner [12] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h30, 8'h30, 8'h40, 8'hf0, 8'h31, 8'h01, 8'h00, 8'h02};
    nqab_link_if link ();
    nqab_host u_nqab_host (.core_clk, .sys_rst, .link(link), .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata_q, .irq_q);
    nqab_device u_nqab_device (.core_clk, .sys_rst, .link(link), .ncq_enabled, .max_queue_tag, .outstanding_tags,
        .streaming_tags, .cancel_strobe_q, .cancel_tags_q, .write_deadline_strict_q, .read_deadline_strict_q,
        .command_error_bits_q, .device_condition_bits_q);
    nqab_link_monitor u_nqab_link_monitor (.core_clk, .sys_rst, .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cmd_feature(link.cmd_feature), .cmd_count(link.cmd_count),
        .cmd_sector(link.cmd_sector), .cmd_devhead(link.cmd_devhead), .dev_ready(link.dev_ready),
        .done_valid(link.done_valid), .done_sdb(link.done_sdb), .queue_active_bits(link.queue_active_bits),
        .done_status(link.done_status), .done_error(link.done_error));
    always #4 core_clk = ~core_clk;
    // hang guard: a run needs about 700 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction
    // expected {success, active bits, cancelled set}
    function automatic logic [64:0] predict(logic [7:0] f, logic [4:0] own, logic [4:0] tt);
        logic        ok;
        logic [31:0] c;
        ok = ncq_enabled && (f[3:0] == 4'h1 || (f[3:0] == 4'h0 && f[7:4] < 4'h4));
        if (f == 8'h30 && (tt == own || tt > max_queue_tag))
            ok = 1'b0;
        case (f)
            8'h00: c = outstanding_tags;
            8'h10: c = outstanding_tags & streaming_tags;
            8'h20: c = outstanding_tags & ~streaming_tags;
            8'h30: c = outstanding_tags & (32'h1 << tt);
            default: c = 32'h0;
        endcase
        c = ok ? c : 32'h0;
        return {ok, ok ? (32'h1 << own) | c : 32'h0, c};
    endfunction
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle register strobes, changed right after the edge
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        q = reg_rdata_q;
    endtask
    // issue one command and follow it to the cleared interrupt
    task automatic run_op(logic [7:0] f, logic [4:0] own, logic [4:0] tt, logic [1:0] m);
        logic [64:0] e;
        logic [31:0] q;
        int          n;
        wr(NQAB_REG_MASK, {30'h0, m});
        e = predict(f, own, tt);
        wr(NQAB_REG_CMD, {11'h0, tt, 3'h0, own, f});
        n = 0;
        while (link.done_valid !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("done", 32'h1, {31'h0, link.done_valid});
        chk("sdb", {31'h0, e[64]}, {31'h0, link.done_sdb});
        chk("active", e[63:32], link.queue_active_bits);
        chk("cancel", e[31:0], cancel_strobe_q === 1'b1 ? cancel_tags_q : 32'h0);
        rd(NQAB_REG_EVENTS, q);
        chk("events", e[64] ? 32'h1 : 32'h2, q);
        chk("irq", {31'h0, |((e[64] ? 2'h1 : 2'h2) & m)}, {31'h0, irq_q});
        if (e[64] && f[3:0] == 4'h1)
            chk("strict", {30'h0, f[5:4]}, {30'h0, read_deadline_strict_q, write_deadline_strict_q});
        wr(NQAB_REG_EVENTS, 32'h3);
        rd(NQAB_REG_RESULT, q);
        chk("result", e[64] ? 32'h50 : 32'h451, q);
        chk("bytes", e[64] ? 32'h50 : 32'h451, {16'h0, command_error_bits_q, device_condition_bits_q});
        chk("irq clear", 32'h0, {31'h0, irq_q});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(4'h2, q);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 48; i++) begin
            r = lfsr();
            if (i == 24) begin
                // reset again mid-run, result must fall back
                @(posedge core_clk);
                sys_rst <= 1'b1;
                repeat (3) @(posedge core_clk);
                sys_rst <= 1'b0;
                rd(NQAB_REG_RESULT, q);
                chk("reset", 32'h0, q);
            end
            @(posedge core_clk);
            ncq_enabled <= (i != 10);
            max_queue_tag <= i < 12 ? 5'h0f : r[25:21];
            outstanding_tags <= lfsr();
            streaming_tags <= lfsr();
            run_op(i < 12 ? corner[i] : {1'b0, r[6:4], 2'h0, r[1:0]}, r[12:8],
                i == 4 ? r[12:8] : {(i < 12 ? i == 5 : r[20]), r[19:16]}, r[27:26]);
        end
        results();
    end
endmodule // ncq_queue_abort_subcommand_test
